// File: inc/iou_cfg.svh
`ifndef IOU_CFG_SVH
`define IOU_CFG_SVH

// device address field, low ten bits of the first register
`define IOU_DEVADR_W      10
// response window in ns and the 50 MHz clock period in ns
`define IOU_RESP_NS       2000
`define IOU_CLK_NS        20
`define IOU_RESP_CYC      ((`IOU_RESP_NS) / (`IOU_CLK_NS))
// condition code values, bit 3 = C, bit 2 = V, bit 1 = G, bit 0 = L
`define IOU_CC_OK         4'h0
`define IOU_CC_TMO        4'h4
// status byte returned for a device that is not present
`define IOU_ABSENT_STAT   8'h04
// bus cycle kinds driven on dev_kind
`define IOU_KIND_CMD      2'h0
`define IOU_KIND_STAT     2'h1
`define IOU_KIND_RD       2'h2
`define IOU_KIND_WR       2'h3

`endif

// File: inc/iou_pkg.sv
package iou_pkg;

   // programmed i/o operation decoded by the pipeline
   typedef enum logic [2:0] {
      IOU_OP_CMD   = 3'h0,   // output_command
      IOU_OP_SENSE = 3'h1,   // sense_status
      IOU_OP_RDB   = 3'h2,   // read_data
      IOU_OP_RDH   = 3'h3,   // read_two_byte
      IOU_OP_WRB   = 3'h4,   // write_data
      IOU_OP_WRH   = 3'h5    // write_two_byte
   } iou_op_e;

   // one instruction handed over from the pipeline
   typedef struct packed {
      logic        valid;
      iou_op_e     op;
      logic        reg_form;   // register-to-register form
      logic [31:0] r1;         // first_reg_field register contents
      logic [31:0] r2;         // second_reg_field register contents
      logic [15:0] mem_opnd;   // halfword operand, byte operand in [7:0]
   } iou_instr_s;

   // answer lines from the device controllers
   typedef struct packed {
      logic        ack;        // device sync
      logic        err;        // incorrect response
      logic        hw;         // device is halfword oriented
      logic [15:0] rdata;
   } iou_dev_in_s;

endpackage

// File: hdl/iou_unit.sv
`timescale 1ns/100ps
`include "iou_cfg.svh"
module iou_unit
   import iou_pkg::*;
#(
   parameter int RESP_CYC = `IOU_RESP_CYC
)(
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire iou_instr_s                instr,
   input  wire logic                      priv_state,
   output logic                           busy,
   output logic                           done,
   output logic                           priv_fault,
   output logic [3:0]                     cc,
   output logic                           reg_we,
   output logic [31:0]                    reg_wdata,
   output logic                           mem_we,
   output logic                           mem_hw,
   output logic [15:0]                    mem_wdata,
   output logic                           dev_req,
   output logic [`IOU_DEVADR_W-1:0]       dev_addr,
   output logic [1:0]                     dev_kind,
   output logic                           dev_wide,
   output logic                           dev_second,
   output logic [15:0]                    dev_wdata,
   input  wire iou_dev_in_s               dev_in
);

   localparam logic [15:0] TMO_LIM = 16'(RESP_CYC);

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_REQ  = 4'h2,
      S_REL  = 4'h4,
      S_FIN  = 4'h8
   } iou_state_e;

   function automatic logic is_two(input iou_op_e op);
      is_two = (op == IOU_OP_RDH) || (op == IOU_OP_WRH);
   endfunction

   function automatic logic [1:0] kind_of(input iou_op_e op);
      unique case (op)
         IOU_OP_CMD:   kind_of = `IOU_KIND_CMD;
         IOU_OP_SENSE: kind_of = `IOU_KIND_STAT;
         IOU_OP_RDB,
         IOU_OP_RDH:   kind_of = `IOU_KIND_RD;
         default:      kind_of = `IOU_KIND_WR;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser on the device answer lines
   iou_dev_in_s sync1_q;
   iou_dev_in_s sync2_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= dev_in;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state
   iou_state_e                 state_q,   state_d;
   iou_op_e                    op_q,      op_d;
   logic                       regf_q,    regf_d;
   logic [`IOU_DEVADR_W-1:0]   addr_q,    addr_d;
   logic [15:0]                data_q,    data_d;
   logic                       phase_q,   phase_d;
   logic                       hw_q,      hw_d;
   logic                       tmo_q,     tmo_d;
   logic [15:0]                timer_q,   timer_d;
   logic                       done_q,    done_d;
   logic                       fault_q,   fault_d;
   logic [3:0]                 cc_q,      cc_d;
   logic                       reg_we_q,  reg_we_d;
   logic [31:0]                reg_wd_q,  reg_wd_d;
   logic                       mem_we_q,  mem_we_d;
   logic                       mem_hw_q,  mem_hw_d;
   logic [15:0]                mem_wd_q,  mem_wd_d;
   logic                       start;

   assign start = instr.valid && (state_q == S_IDLE);

   // next values of the sequencer
   always_comb begin
      state_d  = state_q;
      op_d     = op_q;
      regf_d   = regf_q;
      addr_d   = addr_q;
      data_d   = data_q;
      phase_d  = phase_q;
      hw_d     = hw_q;
      tmo_d    = tmo_q;
      timer_d  = timer_q;
      done_d   = 1'b0;
      fault_d  = 1'b0;
      cc_d     = cc_q;
      reg_we_d = 1'b0;
      reg_wd_d = reg_wd_q;
      mem_we_d = 1'b0;
      mem_hw_d = mem_hw_q;
      mem_wd_d = mem_wd_q;
      unique case (state_q)
         S_IDLE: begin
            if (start && !priv_state) begin
               done_d  = 1'b1;
               fault_d = 1'b1;
            end else if (start) begin
               op_d    = instr.op;
               regf_d  = instr.reg_form;
               addr_d  = instr.r1[`IOU_DEVADR_W-1:0];
               phase_d = 1'b0;
               hw_d    = 1'b0;
               tmo_d   = 1'b0;
               timer_d = '0;
               if (is_two(instr.op))
                  data_d = instr.reg_form ? instr.r2[15:0] : instr.mem_opnd;
               else
                  data_d = {8'h00, instr.reg_form ? instr.r2[7:0] : instr.mem_opnd[7:0]};
               state_d = S_REQ;
            end
         end
         S_REQ: begin
            timer_d = timer_q + 16'h0001;
            if (sync2_q.ack) begin
               if (!phase_q)
                  hw_d = sync2_q.hw;
               if (sync2_q.err)
                  tmo_d = 1'b1;
               if (kind_of(op_q) == `IOU_KIND_RD || kind_of(op_q) == `IOU_KIND_STAT) begin
                  if (!is_two(op_q))
                     data_d = {8'h00, sync2_q.rdata[7:0]};
                  else if (!phase_q && sync2_q.hw)
                     data_d = sync2_q.rdata;
                  else if (!phase_q)
                     data_d = {sync2_q.rdata[7:0], 8'h00};
                  else
                     data_d = {data_q[15:8], sync2_q.rdata[7:0]};
               end
               state_d = S_REL;
            end else if (timer_q >= TMO_LIM) begin
               tmo_d   = 1'b1;
               data_d  = (op_q == IOU_OP_SENSE) ? {8'h00, `IOU_ABSENT_STAT} : data_q;
               state_d = S_FIN;
            end
         end
         S_REL: begin
            timer_d = timer_q + 16'h0001;
            if (!sync2_q.ack) begin
               // second byte follows with no status cycle
               if (is_two(op_q) && !hw_q && !phase_q && !tmo_q) begin
                  phase_d = 1'b1;
                  timer_d = '0;
                  state_d = S_REQ;
               end else begin
                  state_d = S_FIN;
               end
            end else if (timer_q >= TMO_LIM) begin
               tmo_d   = 1'b1;
               state_d = S_FIN;
            end
         end
         S_FIN: begin
            done_d   = 1'b1;
            state_d  = S_IDLE;
            mem_hw_d = is_two(op_q);
            mem_wd_d = data_q;
            if (op_q == IOU_OP_SENSE) begin
               cc_d = tmo_q ? `IOU_CC_TMO : data_q[3:0];
            end else begin
               cc_d = tmo_q ? `IOU_CC_TMO : `IOU_CC_OK;
            end
            // reads write back even on timeout
            if (kind_of(op_q) == `IOU_KIND_RD || op_q == IOU_OP_SENSE) begin
               reg_we_d = regf_q;
               mem_we_d = !regf_q;
               reg_wd_d = is_two(op_q) ? {16'h0000, data_q} : {24'h000000, data_q[7:0]};
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   // register the sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q  <= S_IDLE;
         op_q     <= IOU_OP_CMD;
         regf_q   <= 1'b0;
         addr_q   <= '0;
         data_q   <= '0;
         phase_q  <= 1'b0;
         hw_q     <= 1'b0;
         tmo_q    <= 1'b0;
         timer_q  <= '0;
         done_q   <= 1'b0;
         fault_q  <= 1'b0;
         cc_q     <= `IOU_CC_OK;
         reg_we_q <= 1'b0;
         reg_wd_q <= '0;
         mem_we_q <= 1'b0;
         mem_hw_q <= 1'b0;
         mem_wd_q <= '0;
      end else begin
         state_q  <= state_d;
         op_q     <= op_d;
         regf_q   <= regf_d;
         addr_q   <= addr_d;
         data_q   <= data_d;
         phase_q  <= phase_d;
         hw_q     <= hw_d;
         tmo_q    <= tmo_d;
         timer_q  <= timer_d;
         done_q   <= done_d;
         fault_q  <= fault_d;
         cc_q     <= cc_d;
         reg_we_q <= reg_we_d;
         reg_wd_q <= reg_wd_d;
         mem_we_q <= mem_we_d;
         mem_hw_q <= mem_hw_d;
         mem_wd_q <= mem_wd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; operands are never written for command and write cycles
   // one bus cycle per byte or halfword
   assign busy       = (state_q != S_IDLE);
   assign done       = done_q;
   assign priv_fault = fault_q;
   assign cc         = cc_q;
   assign reg_we     = reg_we_q;
   assign reg_wdata  = reg_wd_q;
   assign mem_we     = mem_we_q;
   assign mem_hw     = mem_hw_q;
   assign mem_wdata  = mem_wd_q;
   assign dev_req    = (state_q == S_REQ);
   assign dev_addr   = addr_q;
   assign dev_kind   = kind_of(op_q);
   assign dev_wide   = is_two(op_q);
   assign dev_second = phase_q;
   assign dev_wdata  = data_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   localparam int ABORT_MAX = 3;

   a_priv_block: assert property (@(posedge mclk) disable iff (!rst_n)
      start && !priv_state |=> done && priv_fault && !busy ##1 (!dev_req || $past(start)))
      else $error("unprivileged instruction reached the bus");

   a_addr_r1: assert property (@(posedge mclk) disable iff (!rst_n)
      start && priv_state |=> dev_req && dev_addr == $past(instr.r1[9:0]))
      else $error("device address not taken from r1 bits 22:31");

   a_absent_stat: assert property (@(posedge mclk) disable iff (!rst_n)
      done && op_q == IOU_OP_SENSE && tmo_q |-> cc == 4'h4 && mem_wdata[7:0] == 8'h04)
      else $error("absent device status wrong");

   a_sense_cc: assert property (@(posedge mclk) disable iff (!rst_n)
      done && op_q == IOU_OP_SENSE && !priv_fault |-> cc == (tmo_q ? 4'h4 : mem_wdata[3:0]))
      else $error("sense cc not equal to status bits 4:7");

   a_byte_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_we && !is_two(op_q) |-> reg_wdata[31:8] == 24'h000000)
      else $error("byte read left upper bits set");

   a_half_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_we && op_q == IOU_OP_RDH |-> reg_wdata[31:16] == 16'h0000 && reg_wdata[15:0] == data_q)
      else $error("halfword read register layout wrong");

   a_tmo_cc: assert property (@(posedge mclk) disable iff (!rst_n)
      done && !priv_fault && op_q != IOU_OP_SENSE |-> cc == (tmo_q ? 4'h4 : 4'h0))
      else $error("condition code does not follow timeout");

   a_no_opnd_wr: assert property (@(posedge mclk) disable iff (!rst_n)
      done && kind_of(op_q) inside {2'h0, 2'h3} |-> !reg_we && !mem_we)
      else $error("command or write modified an operand");

   a_timer_abort: assert property (@(posedge mclk) disable iff (!rst_n)
      dev_req && !sync2_q.ack && timer_q >= TMO_LIM |=> !dev_req ##[1:ABORT_MAX] done && cc[2])
      else $error("response timer did not abort");

   a_rd_tmo_wr: assert property (@(posedge mclk) disable iff (!rst_n)
      done && !priv_fault && op_q == IOU_OP_RDB |-> reg_we || mem_we)
      else $error("read did not write its operand");

   a_no_gap: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == S_REL && !sync2_q.ack && phase_d && !phase_q
      |=> dev_req && dev_second && dev_kind == $past(dev_kind))
      else $error("second byte not issued directly");

   c_two_byte: cover property (@(posedge mclk) disable iff (!rst_n)
      dev_req && dev_second && dev_wide);
   c_timeout: cover property (@(posedge mclk) disable iff (!rst_n)
      done && cc == 4'h4);
   c_sense_ok: cover property (@(posedge mclk) disable iff (!rst_n)
      done && op_q == IOU_OP_SENSE && !tmo_q);

endmodule

// File: test/iou_dev_model.sv
`timescale 1ns/100ps
// device controller on the far side of the i/o bus
module iou_dev_model
   import iou_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        dev_req,
   input  wire logic        dev_second,
   input  wire logic        present,
   input  wire logic        hw_mode,
   input  wire logic        bad_resp,
   input  wire logic [3:0]  delay,
   input  wire logic [15:0] rdata_a,
   input  wire logic [15:0] rdata_b,
   output iou_dev_in_s      dev_in
);
   logic [3:0]  wait_q;
   logic [15:0] last_q;
   logic        ack;
   ////////////////////////////////////////////////////////////
   // response delay counted from the rise of the request
   always @(posedge mclk) begin
      if (!rst_n || !dev_req) begin
         wait_q <= 4'h0;
      end else if (wait_q != 4'hf) begin
         wait_q <= wait_q + 4'h1;
      end
   end
   // released data lines show the inverse of the last value
   always @(posedge mclk) begin
      if (!rst_n) begin
         last_q <= 16'h0000;
      end else if (ack) begin
         last_q <= dev_in.rdata;
      end
   end
   assign ack = present && dev_req && (wait_q >= delay);
   assign dev_in = '{ack, ack && bad_resp, hw_mode,
                     ack ? (dev_second ? rdata_b : rdata_a) : ~last_q};
endmodule

// File: test/io_bus_instruction_unit_bench.sv
`timescale 1ns/100ps
`include "iou_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module io_bus_instruction_unit_bench
   import iou_pkg::*;
;
   localparam logic [31:0] R1 = 32'hfedc_bd5a;
   logic        mclk, rst_n, priv_state, busy, done, priv_fault, reg_we, mem_we, mem_hw;
   logic        dev_req, dev_wide, dev_second, present, hw_mode, bad_resp, req_d, got;
   iou_instr_s  instr;
   iou_dev_in_s dev_in;
   logic [3:0]  cc, delay;
   logic [31:0] reg_wdata;
   logic [15:0] mem_wdata, dev_wdata, rd_a, rd_b;
   logic [9:0]  dev_addr;
   logic [1:0]  dev_kind;
   logic [1:0]  r_kind [64];
   logic        r_sec [64];
   logic        r_wide [64];
   logic [9:0]  r_addr [64];
   logic [15:0] r_wd [64];
   int          err_count, comparisons, cyc, n_x, base;
   ////////////////////////////////////////////////////////////
   iou_unit #(.RESP_CYC(8)) DUT (.mclk(mclk), .rst_n(rst_n), .instr(instr),
      .priv_state(priv_state), .busy(busy), .done(done), .priv_fault(priv_fault),
      .cc(cc), .reg_we(reg_we), .reg_wdata(reg_wdata), .mem_we(mem_we),
      .mem_hw(mem_hw), .mem_wdata(mem_wdata), .dev_req(dev_req), .dev_addr(dev_addr),
      .dev_kind(dev_kind), .dev_wide(dev_wide), .dev_second(dev_second),
      .dev_wdata(dev_wdata), .dev_in(dev_in));
   iou_dev_model PEER (.mclk(mclk), .rst_n(rst_n), .dev_req(dev_req),
      .dev_second(dev_second), .present(present), .hw_mode(hw_mode),
      .bad_resp(bad_resp), .delay(delay), .rdata_a(rd_a), .rdata_b(rd_b),
      .dev_in(dev_in));
   ////////////////////////////////////////////////////////////
   // clock and run limit
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   // log the first 64 bus cycles, each at the rise of its request
   always @(posedge mclk) begin
      req_d <= dev_req;
      if (dev_req && !req_d && n_x < 64) begin
         r_kind[n_x] <= dev_kind;
         r_sec[n_x] <= dev_second;
         r_wide[n_x] <= dev_wide;
         r_addr[n_x] <= dev_addr;
         r_wd[n_x] <= dev_wdata;
         n_x <= n_x + 1;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic test_done();
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // set up the far-side device
   task automatic cfg(input logic p, h, b, input logic [3:0] d, input logic [15:0] a, bb);
      @(posedge mclk);
      present <= p;
      hw_mode <= h;
      bad_resp <= b;
      delay <= d;
      rd_a <= a;
      rd_b <= bb;
   endtask
   // issue one instruction and wait for its completion
   task automatic op(input iou_op_e o, input logic rf, input logic [31:0] r2,
                     input logic [15:0] mem, input logic pv);
      @(posedge mclk);
      base = n_x;
      instr <= '{1'b1, o, rf, R1, r2, mem};
      priv_state <= pv;
      @(posedge mclk);
      instr.valid <= 1'b0;
      #1;
      `CHK("busy", pv, busy)
      got = (done === 1'b1);
      for (int i = 0; i < 80 && !got; i++) begin
         @(posedge mclk);
         #1;
         got = (done === 1'b1);
      end
      `CHK("done", 1'b1, got)
   endtask
   // condition code and number of bus cycles
   task automatic fin(input logic [3:0] c, input int n);
      `CHK("cc", c, cc)
      `CHK("bus cycles", n, n_x - base)
   endtask
   // one logged bus cycle
   task automatic xf(input int k, input logic [1:0] kd, input logic sc,
                     input logic [15:0] wd, input logic [15:0] m);
      `CHK("kind", kd, r_kind[base+k])
      `CHK("second", sc, r_sec[base+k])
      `CHK("addr", R1[9:0], r_addr[base+k])
      `CHK("wdata", wd & m, r_wd[base+k] & m)
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {err_count, comparisons, base} = '0;
      {rst_n, hw_mode, bad_resp, delay, rd_a, rd_b} = '0;
      {priv_state, present} = 2'b11;
      instr = '0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      `CHK("cc", 4'h0, cc)
      op(IOU_OP_CMD, 1'b1, 32'h1234_56c3, 16'h0000, 1'b1);
      fin(`IOU_CC_OK, 1);
      xf(0, `IOU_KIND_CMD, 1'b0, 16'h00c3, 16'h00ff);
      op(IOU_OP_CMD, 1'b0, 32'h0, 16'h77a9, 1'b1);
      xf(0, `IOU_KIND_CMD, 1'b0, 16'h00a9, 16'h00ff);
      op(IOU_OP_WRB, 1'b1, 32'hffff_ff3c, 16'h0000, 1'b1);
      xf(0, `IOU_KIND_WR, 1'b0, 16'h003c, 16'h00ff);
      op(IOU_OP_WRB, 1'b0, 32'h0, 16'h5596, 1'b1);
      xf(0, `IOU_KIND_WR, 1'b0, 16'h0096, 16'h00ff);
      `CHK("reg_we", 1'b0, reg_we | mem_we)
      cfg(1'b1, 1'b0, 1'b0, 4'h0, 16'h5ab6, 16'h0000);
      op(IOU_OP_SENSE, 1'b1, 32'hffff_ffff, 16'h0000, 1'b1);
      fin(4'h6, 1);
      `CHK("sense reg", 32'h0000_00b6, reg_wdata)
      `CHK("reg_we", 1'b1, reg_we)
      op(IOU_OP_SENSE, 1'b0, 32'h0, 16'h0000, 1'b1);
      `CHK("sense mem", 8'hb6, mem_wdata[7:0])
      `CHK("mem_we", 2'b10, {mem_we, mem_hw})
      cfg(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h0000);
      op(IOU_OP_SENSE, 1'b1, 32'hffff_ffff, 16'h0000, 1'b1);
      `CHK("absent cc", `IOU_CC_TMO, cc)
      `CHK("absent stat", {24'h0, `IOU_ABSENT_STAT}, reg_wdata)
      `CHK("status 0:3", 4'h0, reg_wdata[7:4])
      cfg(1'b1, 1'b0, 1'b0, 4'h3, 16'hc75e, 16'h0000);
      op(IOU_OP_RDB, 1'b1, 32'hffff_ffff, 16'h0000, 1'b1);
      fin(`IOU_CC_OK, 1);
      `CHK("read reg", 32'h0000_005e, reg_wdata)
      `CHK("wide", 1'b0, r_wide[base])
      cfg(1'b1, 1'b0, 1'b1, 4'h0, 16'hc75e, 16'h0000);
      op(IOU_OP_RDB, 1'b0, 32'h0, 16'h0000, 1'b1);
      `CHK("bad cc", `IOU_CC_TMO, cc)
      `CHK("mem_we", 1'b1, mem_we)
      cfg(1'b1, 1'b0, 1'b0, 4'hc, 16'hc75e, 16'h0000);
      op(IOU_OP_RDB, 1'b1, 32'h0, 16'h0000, 1'b1);
      `CHK("slow cc", `IOU_CC_TMO, cc)
      cfg(1'b1, 1'b0, 1'b0, 4'h0, 16'h3381, 16'h4442);
      op(IOU_OP_RDH, 1'b1, 32'hffff_ffff, 16'h0000, 1'b1);
      fin(`IOU_CC_OK, 2);
      xf(1, `IOU_KIND_RD, 1'b1, 16'h0, 16'h0);
      `CHK("rh reg", 32'h0000_8142, reg_wdata)
      op(IOU_OP_RDH, 1'b0, 32'h0, 16'h0000, 1'b1);
      `CHK("rh mem", 17'h1_8142, {mem_hw, mem_wdata})
      cfg(1'b1, 1'b1, 1'b0, 4'h0, 16'hbeef, 16'h0000);
      op(IOU_OP_RDH, 1'b1, 32'hffff_ffff, 16'h0000, 1'b1);
      fin(`IOU_CC_OK, 1);
      `CHK("rh hw", 32'h0000_beef, reg_wdata)
      op(IOU_OP_WRH, 1'b1, 32'h9999_c35a, 16'h0000, 1'b1);
      fin(`IOU_CC_OK, 1);
      xf(0, `IOU_KIND_WR, 1'b0, 16'hc35a, 16'hffff);
      cfg(1'b1, 1'b0, 1'b0, 4'h0, 16'h0000, 16'h0000);
      op(IOU_OP_WRH, 1'b1, 32'h9999_c35a, 16'h0000, 1'b1);
      fin(`IOU_CC_OK, 2);
      xf(0, `IOU_KIND_WR, 1'b0, 16'hc300, 16'hff00);
      xf(1, `IOU_KIND_WR, 1'b1, 16'h005a, 16'h00ff);
      `CHK("wide", 2'b11, {r_wide[base], r_wide[base+1]})
      op(IOU_OP_WRH, 1'b0, 32'h0, 16'h1e2d, 1'b1);
      xf(0, `IOU_KIND_WR, 1'b0, 16'h1e00, 16'hff00);
      xf(1, `IOU_KIND_WR, 1'b1, 16'h002d, 16'h00ff);
      cfg(1'b1, 1'b0, 1'b1, 4'h0, 16'h0000, 16'h0000);
      op(IOU_OP_WRH, 1'b1, 32'h0, 16'h0000, 1'b1);
      `CHK("wh cc", `IOU_CC_TMO, cc)
      op(IOU_OP_WRB, 1'b1, 32'h0, 16'h0000, 1'b0);
      fin(`IOU_CC_TMO, 0);
      `CHK("priv_fault", 1'b1, priv_fault)
      test_done();
   end
endmodule
